// *** common/rss_pkg.sv ***
// package of constants and carrier types for the reset source sequencer
package rss_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses on APB)
  // ----------------------------------------------------------------
  localparam logic [11:0] RSS_CAUSE_ADDR = 12'h000;
  localparam logic [11:0] RSS_CTRL_ADDR = 12'h004;
  localparam logic [11:0] RSS_STAT_ADDR = 12'h008;

  // ----------------------------------------------------------------
  // reset cause register fields
  // ----------------------------------------------------------------
  localparam int RSS_POR_BIT = 0;
  localparam int RSS_EXT_BIT = 1;
  localparam int RSS_BOD_BIT = 2;
  localparam int RSS_WDT_BIT = 3;
  localparam logic [3:0] RSS_CAUSE_RESET = 4'h1;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int RSS_CTRL_WDT_EN = 0;
  localparam int RSS_CTRL_WDT_RESTART = 1;
  localparam int RSS_CTRL_ACMP_EN = 2;
  localparam int RSS_CTRL_ACMP_BG = 3;
  localparam int RSS_CTRL_ADC_EN = 4;
  localparam int RSS_CTRL_SLEEP_LO = 8;
  localparam int RSS_CTRL_SLEEP_HI = 10;
  localparam int RSS_CTRL_SLEEPING = 11;
  localparam int RSS_CTRL_WDP_LO = 12;
  localparam int RSS_CTRL_WDP_HI = 14;
  localparam logic [31:0] RSS_CTRL_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int RSS_CLK_MHZ = 100;
  localparam int RSS_TRST_NS = 1500;
  // least time rounds up
  localparam int RSS_TRST_CYC = (RSS_TRST_NS * RSS_CLK_MHZ + 999) / 1000;
  localparam int RSS_WDT_BASE_CYC = 16384;

  // sleep mode codes as written by software
  typedef enum logic [2:0] {
    RSS_SLP_IDLE = 3'h0,
    RSS_SLP_ADCNR = 3'h1,
    RSS_SLP_PDOWN = 3'h2,
    RSS_SLP_PSAVE = 3'h3,
    RSS_SLP_RSV4 = 3'h4,
    RSS_SLP_RSV5 = 3'h5,
    RSS_SLP_STBY = 3'h6,
    RSS_SLP_XSTBY = 3'h7
  } rss_sleep_t;

  // analog detector inputs, grouped
  typedef struct packed {
    logic poweron_low;
    logic brownout_low;
  } rss_detect_t;

  // power gating outputs, grouped
  typedef struct packed {
    logic brownout_detector_on;
    logic watchdog_run;
    logic acmp_on;
    logic vref_on;
    logic adc_on;
    logic adc_extended;
    logic input_buf_en;
  } rss_power_t;

endpackage : rss_pkg

// *** design/rss_sequencer.sv ***
// reset source sequencer with cause register, watchdog and sleep power gating
`timescale 1ns/1ps
module rss_sequencer #(
  parameter int TIMEOUT_SHORT = 6,
  parameter int TIMEOUT_MID = 409600,
  parameter int TIMEOUT_LONG = 6553600,
  parameter int WDT_BASE = rss_pkg::RSS_WDT_BASE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic reset_pin_n,
  input wire rss_pkg::rss_detect_t detect,
  input wire logic [1:0] clock_select_fuses,
  input wire logic brownout_enable_fuse,
  input wire logic brownout_level_fuse,
  input wire logic [7:0] wake_pin_mask,
  output logic internal_reset,
  output logic port_reset,
  output logic brownout_level,
  output rss_pkg::rss_power_t power
);
  import rss_pkg::*;

  localparam int CNT_W = $clog2(TIMEOUT_LONG + 1);
  localparam int WDT_W = $clog2(WDT_BASE * 128 + 1);
  localparam int PIN_W = $clog2(RSS_TRST_CYC + 1);

  typedef enum logic [1:0] {RSS_ST_HOLD, RSS_ST_COUNT, RSS_ST_RUN} rss_state_t;

  // ----------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic pin_low;
  logic por_low;
  logic bod_low;

  // two flops before the sequencing logic reads a pin or detector; port_reset reads them raw
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a <= 3'h7;
      sync_b <= 3'h7;
    end else begin
      sync_a <= {~reset_pin_n, detect.poweron_low, detect.brownout_low};
      sync_b <= sync_a;
    end
  end
  assign pin_low = sync_b[2];
  assign por_low = sync_b[1];
  assign bod_low = sync_b[0] & brownout_enable_fuse;

  // ----------------------------------------------------------------
  // pin pulse width filter
  // ----------------------------------------------------------------
  logic [PIN_W-1:0] pin_cnt;
  logic pin_reset;

  // short glitches are ignored; a held low becomes a pin reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_cnt <= '0;
    end else if (!pin_low) begin
      pin_cnt <= '0;
    end else if (pin_cnt != PIN_W'(RSS_TRST_CYC)) begin
      pin_cnt <= pin_cnt + PIN_W'(1);
    end
  end
  assign pin_reset = pin_low && (pin_cnt == PIN_W'(RSS_TRST_CYC));

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl;
  logic [3:0] cause;
  logic wr_en;
  logic rd_en;
  logic hit;
  logic wdt_pulse;
  rss_sleep_t sleep_mode;
  logic sleeping;

  assign hit = (paddr == RSS_CAUSE_ADDR) || (paddr == RSS_CTRL_ADDR) ||
               (paddr == RSS_STAT_ADDR);
  assign wr_en = psel && penable && pwrite && hit;
  assign rd_en = psel && !pwrite; // unmapped reads load zero
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;

  // control register, cleared by any internal reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= RSS_CTRL_RESET;
    end else if (internal_reset) begin
      ctrl <= RSS_CTRL_RESET;
    end else if (wr_en && paddr == RSS_CTRL_ADDR) begin
      ctrl <= pwdata;
    end else begin
      ctrl[RSS_CTRL_WDT_RESTART] <= 1'b0; // restart bit self-clears
    end
  end
  assign sleep_mode = rss_sleep_t'(ctrl[RSS_CTRL_SLEEP_HI:RSS_CTRL_SLEEP_LO]);
  assign sleeping = ctrl[RSS_CTRL_SLEEPING];

  // cause flags: hardware set wins over a software zero write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause <= RSS_CAUSE_RESET;
    end else if (por_low) begin
      cause <= RSS_CAUSE_RESET;
    end else begin
      cause[RSS_POR_BIT] <= (wr_en && paddr == RSS_CAUSE_ADDR) ?
                            pwdata[RSS_POR_BIT] & cause[RSS_POR_BIT] : cause[RSS_POR_BIT];
      cause[RSS_EXT_BIT] <= pin_reset | ((wr_en && paddr == RSS_CAUSE_ADDR) ?
                            pwdata[RSS_EXT_BIT] & cause[RSS_EXT_BIT] : cause[RSS_EXT_BIT]);
      cause[RSS_BOD_BIT] <= bod_low | ((wr_en && paddr == RSS_CAUSE_ADDR) ?
                            pwdata[RSS_BOD_BIT] & cause[RSS_BOD_BIT] : cause[RSS_BOD_BIT]);
      cause[RSS_WDT_BIT] <= wdt_pulse | ((wr_en && paddr == RSS_CAUSE_ADDR) ?
                            pwdata[RSS_WDT_BIT] & cause[RSS_WDT_BIT] : cause[RSS_WDT_BIT]);
    end
  end

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  logic [WDT_W-1:0] wdt_cnt;
  logic [WDT_W-1:0] wdt_limit;
  logic wdt_en;

  assign wdt_en = ctrl[RSS_CTRL_WDT_EN];
  assign wdt_limit = WDT_W'(WDT_BASE) << ctrl[RSS_CTRL_WDP_HI:RSS_CTRL_WDP_LO];

  // sleep does not stop it; only disable, restart or reset does
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_cnt <= '0;
      wdt_pulse <= 1'b0;
    end else if (internal_reset || !wdt_en || ctrl[RSS_CTRL_WDT_RESTART]) begin
      wdt_cnt <= '0;
      wdt_pulse <= 1'b0;
    end else if (wdt_cnt == wdt_limit - WDT_W'(1)) begin
      wdt_cnt <= '0;
      wdt_pulse <= 1'b1;
    end else begin
      wdt_cnt <= wdt_cnt + WDT_W'(1);
      wdt_pulse <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // reset sequencing
  // ----------------------------------------------------------------
  rss_state_t state;
  logic [CNT_W-1:0] dly_cnt;
  logic [CNT_W-1:0] dly_len;
  logic any_cause;

  // fuse-selected stretch length
  function automatic logic [CNT_W-1:0] timeout_sel(input logic [1:0] sel);
    logic [CNT_W-1:0] len;
    len = CNT_W'(TIMEOUT_LONG);
    if (sel == 2'h0) len = CNT_W'(TIMEOUT_SHORT);
    else if (sel == 2'h1) len = CNT_W'(TIMEOUT_MID);
    return len;
  endfunction : timeout_sel

  assign dly_len = timeout_sel(clock_select_fuses);
  assign any_cause = por_low | pin_reset | bod_low | wdt_pulse;

  // a cause always drops back to hold, so the count starts afresh
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= RSS_ST_HOLD;
      dly_cnt <= '0;
    end else if (any_cause) begin
      state <= RSS_ST_HOLD;
      dly_cnt <= '0;
    end else begin
      unique case (state)
        RSS_ST_HOLD: begin
          state <= RSS_ST_COUNT;
          dly_cnt <= '0;
        end
        RSS_ST_COUNT: begin
          if (dly_cnt >= dly_len - CNT_W'(1)) begin
            state <= RSS_ST_RUN;
          end
          dly_cnt <= dly_cnt + CNT_W'(1);
        end
        RSS_ST_RUN: begin
          dly_cnt <= '0;
        end
      endcase
    end
  end

  // combinational assertion so a cause acts in its own cycle; release waits for state RSS_ST_RUN
  assign internal_reset = (state != RSS_ST_RUN) || any_cause;
  // pins reset without the clock: raw inputs plus global reset, ORed with internal_reset
  assign port_reset = !presetn || !reset_pin_n || detect.poweron_low ||
                      (detect.brownout_low && brownout_enable_fuse) ||
                      internal_reset;
  assign brownout_level = brownout_level_fuse;

  // ----------------------------------------------------------------
  // power gating
  // ----------------------------------------------------------------
  logic io_adc_stopped;
  logic acmp_allowed;
  logic adc_was_off;

  assign io_adc_stopped = sleeping && !(sleep_mode == RSS_SLP_IDLE ||
                                        sleep_mode == RSS_SLP_ADCNR);
  assign acmp_allowed = !sleeping || sleep_mode == RSS_SLP_IDLE ||
                        sleep_mode == RSS_SLP_ADCNR;

  // remembers an off period so the next conversion is the long one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_was_off <= 1'b1;
    end else if (!ctrl[RSS_CTRL_ADC_EN]) begin
      adc_was_off <= 1'b1;
    end else if (wr_en && paddr == RSS_STAT_ADDR) begin
      adc_was_off <= 1'b0; // first conversion acknowledged
    end
  end

  always_comb begin
    power.brownout_detector_on = brownout_enable_fuse;
    power.watchdog_run = wdt_en;
    // reference-fed comparator is kept on in every mode, which costs power
    power.acmp_on = ctrl[RSS_CTRL_ACMP_EN] &&
                    (acmp_allowed || ctrl[RSS_CTRL_ACMP_BG]);
    power.adc_on = ctrl[RSS_CTRL_ADC_EN];
    power.adc_extended = adc_was_off && ctrl[RSS_CTRL_ADC_EN];
    power.vref_on = brownout_enable_fuse ||
                    (ctrl[RSS_CTRL_ACMP_EN] && ctrl[RSS_CTRL_ACMP_BG]) ||
                    ctrl[RSS_CTRL_ADC_EN];
    power.input_buf_en = !io_adc_stopped;
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en && !penable) begin
      unique case (paddr)
        RSS_CAUSE_ADDR: prdata <= {28'h0000000, cause};
        RSS_CTRL_ADDR: prdata <= ctrl;
        RSS_STAT_ADDR: prdata <= {16'h0000, wake_pin_mask, 1'b0, io_adc_stopped,
                                  power.adc_extended, power.vref_on, 2'(state),
                                  brownout_enable_fuse, internal_reset};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule : rss_sequencer

// *** verification/rss_sequencer_monitor.sv ***
// checker of reset stretching and power gating at the sequencer ports
`timescale 1ns/1ps
module rss_sequencer_monitor #(
  parameter int TIMEOUT_SHORT = 6,
  parameter int TIMEOUT_MID = 409600,
  parameter int TIMEOUT_LONG = 6553600
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic reset_pin_n,
  input wire rss_pkg::rss_detect_t detect,
  input wire logic [1:0] clock_select_fuses,
  input wire logic brownout_enable_fuse,
  input wire logic internal_reset,
  input wire logic port_reset,
  input wire rss_pkg::rss_power_t power
);
  import rss_pkg::*;
  int quiet;
  int dly;
  logic cause_on;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ------------------------------------------------
  // helper logic
  // ------------------------------------------------
  // stretch length as the fuses select it
  assign dly = (clock_select_fuses == 2'h0) ? TIMEOUT_SHORT :
    (clock_select_fuses == 2'h1) ? TIMEOUT_MID : TIMEOUT_LONG;
  assign cause_on = !reset_pin_n || detect.poweron_low ||
    (brownout_enable_fuse && detect.brownout_low);
  // cycles since a visible cause; saturates so it never wraps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quiet <= 0;
    end else if (cause_on) begin
      quiet <= 0;
    end else if (quiet < 10000000) begin
      quiet <= quiet + 1;
    end
  end
  // ------------------------------------------------
  // assertions
  // ------------------------------------------------
  port_now_a: assert property (cause_on |-> port_reset)
    else $error("port reset not forced");
  por_fast_a: assert property (detect.poweron_low |-> ##[0:4] internal_reset)
    else $error("power-on low without reset");
  bod_fast_a: assert property (brownout_enable_fuse && detect.brownout_low |-> ##[0:4] internal_reset)
    else $error("brown-out without reset");
  stretch_min_a: assert property ($fell(internal_reset) |-> quiet >= dly)
    else $error("reset released early");
  release_max_a: assert property (quiet == dly + 8 |-> !internal_reset)
    else $error("reset released late");
  hold_after_rise_a: assert property ($rose(internal_reset) |=> internal_reset [*6])
    else $error("reset not stretched");
  bod_sleep_a: assert property (brownout_enable_fuse |-> power.brownout_detector_on)
    else $error("detector off with fuse set");
  vref_bod_a: assert property (brownout_enable_fuse |-> power.vref_on)
    else $error("reference off with fuse set");
  vref_adc_a: assert property (power.adc_on |-> power.vref_on)
    else $error("reference off with adc on");
  rise_c: cover property ($rose(internal_reset));
  fall_c: cover property ($fell(internal_reset));
  ext_c: cover property (power.adc_extended);
endmodule : rss_sequencer_monitor

bind rss_sequencer rss_sequencer_monitor #(.TIMEOUT_SHORT(TIMEOUT_SHORT),
  .TIMEOUT_MID(TIMEOUT_MID), .TIMEOUT_LONG(TIMEOUT_LONG)) u_mon (
  .pclk(pclk), .presetn(presetn), .reset_pin_n(reset_pin_n), .detect(detect),
  .clock_select_fuses(clock_select_fuses), .brownout_enable_fuse(brownout_enable_fuse),
  .internal_reset(internal_reset), .port_reset(port_reset), .power(power));

// *** verification/rss_sequencer_tb_top.sv ***
// self-checking bench for the reset source sequencer
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH %0t got %0h want %0h", $time, g, e); end end
module rss_sequencer_tb_top;
  import rss_pkg::*;
  localparam int TS = 6;
  localparam int TM = 20;
  localparam int TL = 40;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err;
  logic reset_pin_n, brownout_enable_fuse, internal_reset, port_reset;
  logic [1:0] clock_select_fuses;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  rss_detect_t detect;
  rss_power_t power;
  int mismatches, compares, n;
  int dly_tab [3] = '{TS, TM, TL};
  // ------------------------------------------------
  // device and clock
  // ------------------------------------------------
  // shortened counts keep the run brief
  rss_sequencer #(.TIMEOUT_SHORT(TS), .TIMEOUT_MID(TM), .TIMEOUT_LONG(TL), .WDT_BASE(16)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reset_pin_n(reset_pin_n), .detect(detect), .clock_select_fuses(clock_select_fuses),
    .brownout_enable_fuse(brownout_enable_fuse), .brownout_level_fuse(1'b0),
    .wake_pin_mask(8'h00), .internal_reset(internal_reset), .port_reset(port_reset),
    .brownout_level(), .power(power));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // ------------------------------------------------
  // tasks
  // ------------------------------------------------
  task automatic give_verdict();
    if (mismatches == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict
  // request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      mismatches++;
      give_verdict();
    end
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    `CHK(q, e)
  endtask : rd
  // bounded wait for release, counting edges
  task automatic wait_rel(output int c);
    c = 0;
    while (internal_reset !== 1'b0) begin
      @(posedge pclk);
      c++;
      if (c > 2000) begin
        mismatches++;
        give_verdict();
      end
    end
  endtask : wait_rel
  function automatic logic [31:0] cw(input logic [4:0] b, input logic [2:0] m, input logic s);
    return {20'h00000, s, m, 3'h0, b};
  endfunction : cw
  // ------------------------------------------------
  // scenarios
  // ------------------------------------------------
  task automatic s_start();
    `CHK(internal_reset, 1'b1)
    wait_rel(n);
    `CHK(n >= TS && n <= TS + 8, 1'b1)
    rd(RSS_CTRL_ADDR, RSS_CTRL_RESET);
    rd(RSS_STAT_ADDR, 32'h8);
    rd(RSS_CAUSE_ADDR, 32'h1);
    rd(12'h00C, 32'h0);
    `CHK(last_err, 1'b1)
  endtask : s_start
  // pin reset under each fuse-selected stretch
  task automatic s_pin();
    for (int f = 0; f < 3; f++) begin
      clock_select_fuses <= f[1:0];
      wr(RSS_CAUSE_ADDR, 32'h0);
      reset_pin_n <= 1'b0;
      @(posedge pclk);
      #1;
      `CHK(port_reset, 1'b1)
      repeat (RSS_TRST_CYC + 10) @(posedge pclk);
      `CHK(internal_reset, 1'b1)
      reset_pin_n <= 1'b1;
      wait_rel(n);
      `CHK(n >= dly_tab[f] && n <= dly_tab[f] + 8, 1'b1)
      rd(RSS_CAUSE_ADDR, 32'h2);
    end
    clock_select_fuses <= 2'h0;
  endtask : s_pin
  task automatic s_bod();
    detect.brownout_low <= 1'b1;
    repeat (10) @(posedge pclk);
    `CHK(internal_reset, 1'b0)
    `CHK(power.vref_on, 1'b0)
    detect.brownout_low <= 1'b0;
    brownout_enable_fuse <= 1'b1;
    repeat (2) @(posedge pclk);
    `CHK(power.brownout_detector_on, 1'b1)
    detect.brownout_low <= 1'b1;
    repeat (5) @(posedge pclk);
    `CHK(internal_reset, 1'b1)
    detect.brownout_low <= 1'b0;
    wait_rel(n);
    `CHK(n >= TS && n <= TS + 8, 1'b1)
    rd(RSS_CAUSE_ADDR, 32'h6);
    brownout_enable_fuse <= 1'b0;
    detect.poweron_low <= 1'b1;
    repeat (5) @(posedge pclk);
    `CHK(internal_reset, 1'b1)
    detect.poweron_low <= 1'b0;
    repeat (5) @(posedge pclk);
    // short dip while counting must restart the stretch
    detect.poweron_low <= 1'b1;
    @(posedge pclk);
    detect.poweron_low <= 1'b0;
    wait_rel(n);
    `CHK(n >= TS + 2 && n <= TS + 8, 1'b1)
    rd(RSS_CAUSE_ADDR, 32'h1);
  endtask : s_bod
  // restarts keep it quiet; then it must fire
  task automatic s_wdt();
    repeat (8) wr(RSS_CTRL_ADDR, cw(5'h03, 3'h0, 1'b0));
    `CHK(internal_reset, 1'b0)
    // prescale one doubles the period
    wr(RSS_CTRL_ADDR, cw(5'h01, RSS_SLP_PDOWN, 1'b1) | 32'h0000_1000);
    `CHK(power.watchdog_run, 1'b1)
    n = 0;
    while (internal_reset !== 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    `CHK(n > 16 && n <= 40, 1'b1)
    wait_rel(n);
    `CHK(n >= TS && n <= TS + 2, 1'b1)
    rd(RSS_CAUSE_ADDR, 32'h9);
    rd(RSS_CTRL_ADDR, 32'h0);
  endtask : s_wdt
  task automatic s_power();
    wr(RSS_CTRL_ADDR, cw(5'h0C, RSS_SLP_PDOWN, 1'b1));
    `CHK(power.vref_on, 1'b1)
    `CHK(power.input_buf_en, 1'b0)
    for (int m = 0; m < 8; m++) begin
      if (m != 4 && m != 5) begin
        wr(RSS_CTRL_ADDR, cw(5'h04, m[2:0], 1'b1));
        `CHK(power.acmp_on, m < 2)
      end
    end
    wr(RSS_CTRL_ADDR, cw(5'h04, RSS_SLP_IDLE, 1'b1));
    `CHK(power.input_buf_en, 1'b1)
    `CHK(power.vref_on, 1'b0)
    wr(RSS_CTRL_ADDR, cw(5'h10, RSS_SLP_PDOWN, 1'b1));
    `CHK(power.adc_on, 1'b1)
    wr(RSS_STAT_ADDR, 32'h0);
    `CHK(power.adc_extended, 1'b0)
    wr(RSS_CTRL_ADDR, 32'h0);
    wr(RSS_CTRL_ADDR, cw(5'h10, 3'h0, 1'b0));
    `CHK(power.adc_extended, 1'b1)
  endtask : s_power
  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial begin
    mismatches = 0;
    compares = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, brownout_enable_fuse} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    reset_pin_n = 1'b1;
    detect = '0;
    clock_select_fuses = 2'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    s_start();
    s_pin();
    s_bod();
    s_wdt();
    s_power();
    give_verdict();
  end
endmodule : rss_sequencer_tb_top
